// ==== core/tbr_consts.svh ====
`ifndef TBR_CONSTS_SVH
`define TBR_CONSTS_SVH
`define TBR_ADDR_W 6
`define TBR_OFS_LATCH 6'h0f
`define TBR_OFS_FLAGS 6'h0b
`define TBR_OFS_VALID 6'h05
`define TBR_OFS_CNT 6'h20
`define TBR_OFS_PER 6'h26
`define TBR_OFS_CMP 6'h28
`define TBR_OFS_PERSH 6'h36
`define TBR_OFS_CMPSH 6'h38
`define TBR_RST_PER 16'hffff
`define TBR_RST_ZERO 16'h0000
`define TBR_RST_LATCH 8'h00
`define TBR_BIT_PSV 0
`define TBR_BIT_CMP0 4
`endif

// ==== core/tbr_pkg.sv ====
package tbr_pkg;
	typedef logic [15:0] tbr_word_t;
	typedef logic [7:0] tbr_byte_t;
endpackage

// ==== core/tbr_regs.sv ====
`timescale 1ns/100ps
`include "tbr_consts.svh"
// Summary of operation
// - one byte latch gives atomic word access
// - latch shared by all words, software readable/writable
// - low byte at base, high at base+1
// - bus write to counter beats internal update
// - period supplies top, resets to all ones
// - three compares checked against counter continuously
// - update loads each compare from its shadow
// - period shadow write sets its valid bit
// - compare shadow write sets its valid bit
// - update clears compare shadow valid bits
// - update clears period shadow valid bit
// - match sets compare flag, write one clears
module tbr_regs
	import tbr_pkg::*;
#(
	parameter int NCH = 3
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [`TBR_ADDR_W-1:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	input wire logic cnt_load,
	input wire logic [15:0] cnt_next,
	input wire logic update,
	output logic [15:0] counter_value,
	output logic [15:0] period_top_value,
	output logic [NCH-1:0] cmp_match,
	output logic [NCH-1:0] cmp_flag,
	output logic period_shadow_valid,
	output logic [NCH-1:0] compare_shadow_valid
);
	tbr_byte_t latch_r, latch_nxt;
	tbr_word_t cnt_r, cnt_nxt, per_r, per_nxt, persh_r, persh_nxt;
	tbr_word_t cmp_r [NCH], cmp_nxt [NCH], cmpsh_r [NCH], cmpsh_nxt [NCH];
	logic psv_r, psv_nxt;
	logic [NCH-1:0] cbv_r, cbv_nxt, flg_r, flg_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic hi;
	logic [`TBR_ADDR_W-1:0] base;
	tbr_word_t wword;
	logic [NCH-1:0] hit_cmp, hit_cmpsh;
	logic is_word;

	assign hi = addr[0];
	assign base = {addr[`TBR_ADDR_W-1:1], 1'b0};
	// low-byte writes elsewhere must not disturb the latch
	assign is_word = (base == `TBR_OFS_CNT) || (base == `TBR_OFS_PER) ||
		(base == `TBR_OFS_PERSH) || (|hit_cmp) || (|hit_cmpsh);
	assign wword = {wdata, latch_r};

	always_comb
	begin
		latch_nxt = latch_r;
		cnt_nxt = cnt_r;
		per_nxt = per_r;
		persh_nxt = persh_r;
		psv_nxt = psv_r;
		cbv_nxt = cbv_r;
		flg_nxt = flg_r;
		rdata_nxt = 8'h00;
		for (int i = 0; i < NCH; i++)
		begin
			cmp_nxt[i] = cmp_r[i];
			cmpsh_nxt[i] = cmpsh_r[i];
		end
		if (cnt_load)
			cnt_nxt = cnt_next;
		if (update)
		begin
			for (int i = 0; i < NCH; i++)
				cmp_nxt[i] = cmpsh_r[i];
			if (psv_r)
				per_nxt = persh_r;
			cbv_nxt = '0;
			psv_nxt = 1'b0;
		end
		if (wr_en)
		begin
			if (addr == `TBR_OFS_LATCH)
				latch_nxt = wdata;
			else if (addr == `TBR_OFS_FLAGS)
				flg_nxt = flg_r & ~wdata[`TBR_BIT_CMP0 +: NCH];
			else if (addr == `TBR_OFS_VALID)
			begin
				psv_nxt = wdata[`TBR_BIT_PSV];
				cbv_nxt = wdata[`TBR_BIT_PSV+1 +: NCH];
			end
			else if (!hi && is_word)
				latch_nxt = wdata;
			else if (base == `TBR_OFS_CNT)
				cnt_nxt = wword;
			else if (base == `TBR_OFS_PER)
				per_nxt = wword;
			else if (base == `TBR_OFS_PERSH)
			begin
				persh_nxt = wword;
				psv_nxt = 1'b1;
			end
			for (int i = 0; i < NCH; i++)
			begin
				if (hi && base == `TBR_OFS_CMP + 6'(2*i))
					cmp_nxt[i] = wword;
				if (hi && base == `TBR_OFS_CMPSH + 6'(2*i))
				begin
					cmpsh_nxt[i] = wword;
					cbv_nxt[i] = 1'b1;
				end
			end
		end
		// match sets flag, wins over clear
		flg_nxt = flg_nxt | cmp_match;
		if (rd_en)
		begin
			if (addr == `TBR_OFS_LATCH)
				rdata_nxt = latch_r;
			else if (addr == `TBR_OFS_FLAGS)
				rdata_nxt = 8'({flg_r, 4'h0});
			else if (addr == `TBR_OFS_VALID)
				rdata_nxt = 8'({cbv_r, psv_r});
			else if (hi && !wr_en)
				rdata_nxt = latch_r;
			else if (base == `TBR_OFS_CNT)
			begin
				rdata_nxt = cnt_r[7:0];
				latch_nxt = cnt_r[15:8];
			end
			else if (base == `TBR_OFS_PER)
			begin
				rdata_nxt = per_r[7:0];
				latch_nxt = per_r[15:8];
			end
			else if (base == `TBR_OFS_PERSH)
			begin
				rdata_nxt = persh_r[7:0];
				latch_nxt = persh_r[15:8];
			end
			for (int i = 0; i < NCH; i++)
			begin
				if (!hi && base == `TBR_OFS_CMP + 6'(2*i))
				begin
					rdata_nxt = cmp_r[i][7:0];
					latch_nxt = cmp_r[i][15:8];
				end
				if (!hi && base == `TBR_OFS_CMPSH + 6'(2*i))
				begin
					rdata_nxt = cmpsh_r[i][7:0];
					latch_nxt = cmpsh_r[i][15:8];
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			latch_r <= `TBR_RST_LATCH;
			cnt_r <= `TBR_RST_ZERO;
			per_r <= `TBR_RST_PER;
			persh_r <= `TBR_RST_PER;
			psv_r <= 1'b0;
			cbv_r <= '0;
			flg_r <= '0;
			rdata_r <= 8'h00;
			for (int i = 0; i < NCH; i++)
			begin
				cmp_r[i] <= `TBR_RST_ZERO;
				cmpsh_r[i] <= `TBR_RST_ZERO;
			end
		end
		else
		begin
			latch_r <= latch_nxt;
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			persh_r <= persh_nxt;
			psv_r <= psv_nxt;
			cbv_r <= cbv_nxt;
			flg_r <= flg_nxt;
			rdata_r <= rdata_nxt;
			for (int i = 0; i < NCH; i++)
			begin
				cmp_r[i] <= cmp_nxt[i];
				cmpsh_r[i] <= cmpsh_nxt[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_cmp
			assign cmp_match[g] = (cnt_r == cmp_r[g]);
			assign hit_cmp[g] = (base == `TBR_OFS_CMP + 6'(2*g));
			assign hit_cmpsh[g] = (base == `TBR_OFS_CMPSH + 6'(2*g));
		end
	endgenerate

	assign rdata = rdata_r;
	assign counter_value = cnt_r;
	assign period_top_value = per_r;
	assign cmp_flag = flg_r;
	assign period_shadow_valid = psv_r;
	assign compare_shadow_valid = cbv_r;

	chk_cnt_write_wins: assert property (@(posedge clk) disable iff (srst)
		(wr_en && hi && base == `TBR_OFS_CNT) |=> cnt_r == $past(wword))
		else $error("counter write lost");
	chk_psv_set: assert property (@(posedge clk) disable iff (srst)
		(wr_en && hi && base == `TBR_OFS_PERSH) |=> psv_r)
		else $error("period valid not set");
	chk_cbv_set: assert property (@(posedge clk) disable iff (srst)
		(wr_en && hi && base == `TBR_OFS_CMPSH) |=> cbv_r[0])
		else $error("compare valid not set");
	chk_cbv_clear: assert property (@(posedge clk) disable iff (srst)
		(update && !wr_en) |=> cbv_r == '0)
		else $error("compare valid not cleared");
	chk_psv_clear: assert property (@(posedge clk) disable iff (srst)
		(update && !wr_en) |=> !psv_r)
		else $error("period valid not cleared");
	chk_cmp_load: assert property (@(posedge clk) disable iff (srst)
		(update && !wr_en) |=> cmp_r[1] == $past(cmpsh_r[1]))
		else $error("compare not loaded");
	chk_per_load: assert property (@(posedge clk) disable iff (srst)
		(update && psv_r && !wr_en) |=> per_r == $past(persh_r))
		else $error("period not loaded");
	chk_flag_set: assert property (@(posedge clk) disable iff (srst)
		cmp_match[0] |=> flg_r[0])
		else $error("compare flag not set");
	chk_low_read: assert property (@(posedge clk) disable iff (srst)
		(rd_en && base == `TBR_OFS_CNT && !hi) |=> latch_r == $past(cnt_r[15:8]))
		else $error("high byte not latched");
	chk_low_write: assert property (@(posedge clk) disable iff (srst)
		(wr_en && !rd_en && !hi && is_word) |=> latch_r == $past(wdata))
		else $error("low byte not parked in latch");
	chk_latch_write: assert property (@(posedge clk) disable iff (srst)
		(wr_en && !rd_en && addr == `TBR_OFS_LATCH) |=> latch_r == $past(wdata))
		else $error("latch write lost");
	chk_latch_read: assert property (@(posedge clk) disable iff (srst)
		(rd_en && addr == `TBR_OFS_LATCH) |=> rdata == $past(latch_r))
		else $error("latch read wrong");
	chk_high_read: assert property (@(posedge clk) disable iff (srst)
		(rd_en && !wr_en && hi && is_word) |=> rdata == $past(latch_r))
		else $error("high byte not from latch");
	chk_per_write: assert property (@(posedge clk) disable iff (srst)
		(wr_en && hi && base == `TBR_OFS_PER) |=> per_r == $past(wword))
		else $error("period word not committed");
	chk_cbv2_set: assert property (@(posedge clk) disable iff (srst)
		(wr_en && hi && hit_cmpsh[NCH-1]) |=> cbv_r[NCH-1])
		else $error("last compare valid not set");
	chk_flag_hold: assert property (@(posedge clk) disable iff (srst)
		(flg_r[0] && !(wr_en && addr == `TBR_OFS_FLAGS && wdata[`TBR_BIT_CMP0]))
		|=> flg_r[0])
		else $error("compare flag dropped");
	chk_flag_clear: assert property (@(posedge clk) disable iff (srst)
		(wr_en && addr == `TBR_OFS_FLAGS && wdata[`TBR_BIT_CMP0] && !cmp_match[0])
		|=> !flg_r[0])
		else $error("compare flag not cleared");
	chk_per_reset: assert property (@(posedge clk)
		srst |=> per_r == `TBR_RST_PER && persh_r == `TBR_RST_PER)
		else $error("period reset value wrong");
	chk_per_keep: assert property (@(posedge clk) disable iff (srst)
		(update && !psv_r && !wr_en) |=> per_r == $past(per_r))
		else $error("period loaded from stale shadow");
endmodule

// ==== verif/tbr_host.sv ====
`timescale 1ns/100ps
module tbr_host(
	input wire logic clk,
	output logic [5:0] addr,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	logic [7:0] rb;
	initial
	begin
		addr = 6'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
	end
	task automatic xfer(input logic [5:0] a, input logic [7:0] d, input logic w);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr_en = w;
		rd_en = !w;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		// idle data line must not keep last byte
		wdata = ~d;
		rb = rdata;
	endtask
	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		xfer(a, v[7:0], 1'b1);
		xfer(a + 6'h01, v[15:8], 1'b1);
	endtask
	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		xfer(a, 8'h00, 1'b0);
		v[7:0] = rb;
		xfer(a + 6'h01, 8'h00, 1'b0);
		v[15:8] = rb;
	endtask
endmodule

// ==== verif/timer_buffered_16bit_regs_tb_top.sv ====
`timescale 1ns/100ps
`include "tbr_consts.svh"
module timer_buffered_16bit_regs_tb_top;
	import tbr_pkg::*;
	localparam logic [5:0] OFS [9] = '{6'h20, 6'h26, 6'h28, 6'h2a, 6'h2c,
		6'h36, 6'h38, 6'h3a, 6'h3c};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cnt_load = 1'b0;
	logic update = 1'b0;
	tbr_word_t cnt_next = 16'h0000;
	logic [5:0] addr;
	logic wr_en, rd_en, pbv;
	logic [7:0] wdata, rdata;
	tbr_word_t cv, pv, v;
	logic [2:0] mt, fl, cbv;
	int failures = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	tbr_regs tbr_regs_i(.clk(clk), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wdata(wdata), .rdata(rdata), .cnt_load(cnt_load), .cnt_next(cnt_next),
		.update(update), .counter_value(cv), .period_top_value(pv), .cmp_match(mt),
		.cmp_flag(fl), .period_shadow_valid(pbv), .compare_shadow_valid(cbv));
	tbr_host tbr_host_i(.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wdata(wdata), .rdata(rdata));
	function automatic tbr_word_t pat(input logic [5:0] a);
		return {2'b10, a, 8'h3c};
	endfunction
	task automatic chk(input tbr_word_t g, input tbr_word_t e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#20000;
		failures++;
		stop_test;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		srst = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			tbr_host_i.rd16(OFS[i], v);
			chk(v, (OFS[i] == 6'h26 || OFS[i] == 6'h36) ? `TBR_RST_PER : `TBR_RST_ZERO);
		end
		$display("test reset values done");
		for (int i = 0; i < 9; i++)
			tbr_host_i.wr16(OFS[i], pat(OFS[i]));
		for (int i = 0; i < 9; i++)
		begin
			tbr_host_i.rd16(OFS[i], v);
			chk(v, pat(OFS[i]));
		end
		chk({15'h0, pbv}, 16'h0001);
		chk({13'h0, cbv}, 16'h0007);
		tbr_host_i.xfer(`TBR_OFS_VALID, 8'h00, 1'b0);
		chk({8'h00, tbr_host_i.rb}, 16'h000f);
		tbr_host_i.xfer(`TBR_OFS_LATCH, 8'ha5, 1'b1);
		tbr_host_i.xfer(`TBR_OFS_LATCH, 8'h00, 1'b0);
		chk({8'h00, tbr_host_i.rb}, 16'h00a5);
		tbr_host_i.xfer(6'h10, 8'h00, 1'b0);
		chk({8'h00, tbr_host_i.rb}, 16'h0000);
		$display("test word access done");
		update = 1'b1;
		@(posedge clk);
		#1;
		update = 1'b0;
		chk({15'h0, pbv}, 16'h0000);
		chk({13'h0, cbv}, 16'h0000);
		chk(pv, pat(6'h36));
		for (int n = 0; n < 3; n++)
		begin
			tbr_host_i.rd16(6'h28 + 6'(2 * n), v);
			chk(v, pat(6'h38 + 6'(2 * n)));
		end
		tbr_host_i.wr16(`TBR_OFS_PERSH, 16'h0f0f);
		tbr_host_i.xfer(`TBR_OFS_VALID, 8'h00, 1'b1);
		update = 1'b1;
		@(posedge clk);
		#1;
		update = 1'b0;
		chk(pv, pat(6'h36));
		$display("test update done");
		cnt_next = 16'h1234;
		cnt_load = 1'b1;
		tbr_host_i.wr16(`TBR_OFS_CNT, 16'hbeef);
		chk(cv, 16'hbeef);
		@(posedge clk);
		#1;
		cnt_load = 1'b0;
		chk(cv, 16'h1234);
		tbr_host_i.xfer(`TBR_OFS_CNT, 8'h00, 1'b0);
		cnt_next = 16'h5678;
		cnt_load = 1'b1;
		tbr_host_i.xfer(`TBR_OFS_CNT + 6'h01, 8'h00, 1'b0);
		cnt_load = 1'b0;
		chk({8'h00, tbr_host_i.rb}, 16'h0012);
		chk(cv, 16'h5678);
		tbr_host_i.xfer(`TBR_OFS_FLAGS, 8'h70, 1'b1);
		chk({13'h0, fl}, 16'h0000);
		tbr_host_i.wr16(`TBR_OFS_CNT, pat(6'h38));
		chk({13'h0, mt}, 16'h0001);
		@(posedge clk);
		#1;
		chk({13'h0, fl}, 16'h0001);
		tbr_host_i.xfer(`TBR_OFS_FLAGS, 8'h00, 1'b0);
		chk({8'h00, tbr_host_i.rb}, 16'h0010);
		$display("test counter and match done");
		stop_test;
	end
endmodule
